// ---- design/tlc_regs.vh ----
`ifndef TLC_REGS_VH
`define TLC_REGS_VH

// apb byte offsets of the word-wide registers
`define TLC_OFS_LOCAL_HI    8'h00
`define TLC_OFS_LOCAL_LO    8'h04
`define TLC_OFS_REMS_HI     8'h08
`define TLC_OFS_REMS_LO     8'h0C
`define TLC_OFS_REMU_HI     8'h10
`define TLC_OFS_REMU_LO     8'h14
`define TLC_OFS_STATUS1     8'h18
`define TLC_OFS_CONFIG1     8'h1C
`define TLC_OFS_CONFIG2     8'h20
`define TLC_OFS_ONESHOT     8'h24
`define TLC_OFS_LOCAL_LIM   8'h28
`define TLC_OFS_REMCRIT_LIM 8'h2C
`define TLC_OFS_REMOT_LIM   8'h30
`define TLC_OFS_PINS        8'h34

// reset values
`define TLC_RST_CONFIG1     8'h00
`define TLC_RST_CONFIG2     8'h1F
`define TLC_RST_LOCAL_LIM   7'h55
`define TLC_RST_REMCRIT_LIM 8'h6E
`define TLC_RST_REMOT_LIM   8'h55

// configuration register 1 fields
`define TLC_C1_LOC_CRIT_MASK 0
`define TLC_C1_LOC_OT_MASK   1
`define TLC_C1_REM_CRIT_MASK 2
`define TLC_C1_REM_OT_MASK   3
`define TLC_C1_STANDBY       6

// configuration register 2 filter enable field
`define TLC_C2_FILTER_HI 2
`define TLC_C2_FILTER_LO 1

// status register 1 fields
`define TLC_S1_BUSY     7
`define TLC_S1_LOC_HIGH 4
`define TLC_S1_REM_CRIT 3
`define TLC_S1_REM_OT   1

// bus timeout timing
`define TLC_TIMEOUT_MIN_US 25000
`define TLC_CLOCK_KHZ      50000

`endif

// ---- design/tlc_sensor.v ----
// Operation
// - local reading compared to shared local limit; masks pick critical and/or overtemp output
// - every limit comparison result readable in status register 1
// - remote reading compared to critical and overtemp limits, each gated by its mask
// - reset limits: remote critical 110, remote overtemp 85, local shared 85
// - both alert outputs open-drain, pulled low when asserted, released otherwise
// - filter on: comparisons use filtered remote reading with finer resolution
// - standby bit stops conversions while bus interface stays active
// - a write to one-shot register starts exactly one round only in standby, else ignored; value not kept
// - one-shot converts local then remote once, then updates both alerts
// - readings left-justified 16-bit words in byte pairs; local is 10-bit plus sign
// - remote reading given at once in 13-bit unsigned and 12-bit plus sign pairs
// - lowest two remote bits carry data only with the filter on, else zero
// - limits unsigned 1 degree per bit; local 7 bits, remote 8 bits
// - temperature registers readable anytime, returning last completed conversion
// - bus line low past timeout resets bus engine and releases the data pin
// - timeout interval lies between 25 ms and 35 ms of continuous low
// - filter field 00 off, 11 on, other codes reserved
// - busy flag high only during conversion; local and remote alternate round-robin
`timescale 1ns/1ps
`default_nettype none
`include "tlc_regs.vh"

module tlc_sensor #(
    parameter TIMEOUT_CYCLES = `TLC_TIMEOUT_MIN_US * (`TLC_CLOCK_KHZ / 1000)
) (
    input  wire        clock,
    input  wire        nrst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // converter front end, same clock
    output reg         convStart,
    output reg         convRemote,
    input  wire        convDone,
    input  wire [10:0] localSample,
    input  wire [13:0] remoteSample,
    input  wire [13:0] remoteFiltered,
    // bus lines and bus engine
    input  wire        smbClkIn,
    input  wire        smbDatIn,
    input  wire        smbDatDriveReq,
    output wire        smbDatOut,
    output wire        smbDatOe,
    output wire        smbClkOut,
    output wire        smbClkOe,
    output reg         smbEngineReset,
    // open-drain alert pins
    input  wire        criticalAlertIn,
    output wire        criticalAlertOut,
    output reg         criticalAlertOe,
    input  wire        overtempAlertIn,
    output wire        overtempAlertOut,
    output reg         overtempAlertOe
);

    localparam ST_IDLE   = 2'd0;
    localparam ST_LOCAL  = 2'd1;
    localparam ST_REMOTE = 2'd2;
    localparam ST_UPDATE = 2'd3;

    // signed 1/256 degree value exceeds an unsigned whole-degree limit;
    // 17 bits so a remote reading past 128 degrees keeps its magnitude
    function gtLimit;
        input [16:0] word;
        input [7:0]  limit;
        begin
            gtLimit = $signed(word) > $signed({1'b0, limit, 8'h00});
        end
    endfunction

    // clamp a 14-bit signed 1/32 degree sample into a left-justified 16-bit word
    function [15:0] clampWord;
        input [13:0] sample;
        input        unsignedFmt;
        input        fine;
        reg   [13:0] v;
        begin
            v = sample;
            if (unsignedFmt && sample[13]) begin
                v = 14'h0000;
            end else if (!unsignedFmt && sample[13:12] == 2'b01) begin
                v = 14'h0FFF;
            end else if (!unsignedFmt && sample[13:12] == 2'b10) begin
                v = 14'h3000;
            end
            if (!fine) begin
                v[1:0] = 2'b00;
            end
            if (unsignedFmt) begin
                clampWord = {v[12:0], 3'b000};
            end else begin
                clampWord = {v[12], v[11:0], 3'b000};
            end
        end
    endfunction

    // sequencer state
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;

    // software settings and limits
    reg [7:0]  config1_r;
    reg [7:0]  config2_r;
    reg [6:0]  localLim_r;
    reg [7:0]  remCritLim_r;
    reg [7:0]  remOtLim_r;
    reg        oneShotPend_r;

    // latest completed results; only whole conversions land here
    reg [15:0] localWord_r;
    reg [13:0] remoteVal_r;
    reg        remoteFine_r;

    // pin synchronisers and bus low-time counter
    reg [1:0]  smbClkSync_r;
    reg [1:0]  smbDatSync_r;
    reg [1:0]  critPinSync_r;
    reg [1:0]  otPinSync_r;
    reg [20:0] lowCount_r;

    // mode decode and bus phase
    wire        standby   = config1_r[`TLC_C1_STANDBY];
    wire        filterOn  = config2_r[`TLC_C2_FILTER_HI:`TLC_C2_FILTER_LO] == 2'b11;
    wire        busy      = (state_r == ST_LOCAL) || (state_r == ST_REMOTE);
    wire        apbWrite  = psel && penable && pwrite;
    wire        apbSetup  = psel && !penable;

    // round boundaries, shared by the sequencer and the one-shot request
    wire        roundStart = (state_r == ST_IDLE) && (state_nxt == ST_LOCAL);
    wire        localDone  = (state_r == ST_LOCAL) && convDone;
    wire        remoteDone = (state_r == ST_REMOTE) && convDone;

    // two read views of the one stored remote value
    wire [15:0] remSigned = clampWord(remoteVal_r, 1'b0, remoteFine_r);
    wire [15:0] remUnsign = clampWord(remoteVal_r, 1'b1, remoteFine_r);
    // comparison operands at 1/256 degree
    wire [16:0] localCmp  = {localWord_r[15], localWord_r};
    wire [16:0] remCmp    = {remoteVal_r, 3'b000};

    // comparisons against the latest completed set; masks do not touch these
    wire localHigh = gtLimit(localCmp, {1'b0, localLim_r});
    wire remCrit   = gtLimit(remCmp, remCritLim_r);
    wire remOt     = gtLimit(remCmp, remOtLim_r);

    // unmasked paths onto each output
    wire critAny = (localHigh && !config1_r[`TLC_C1_LOC_CRIT_MASK])
                || (remCrit && !config1_r[`TLC_C1_REM_CRIT_MASK]);
    wire otAny   = (localHigh && !config1_r[`TLC_C1_LOC_OT_MASK])
                || (remOt && !config1_r[`TLC_C1_REM_OT_MASK]);

    // saturating compare; 21 bits cover the 25 ms default at 50 MHz
    wire timedOut = lowCount_r >= TIMEOUT_CYCLES[20:0];

    // open-drain pins sit at zero and only the enables move; no clock stretching
    assign pready           = 1'b1;
    assign criticalAlertOut = 1'b0;
    assign overtempAlertOut = 1'b0;
    assign smbDatOut        = 1'b0;
    assign smbClkOut        = 1'b0;
    assign smbClkOe         = 1'b0; // clock line is only ever an input
    assign smbDatOe         = smbDatDriveReq && !smbEngineReset;

    // conversion round-robin: local then remote, then refresh alerts
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                // standby parks here until a one-shot request is pending
                if (!standby || oneShotPend_r) begin
                    state_nxt = ST_LOCAL;
                end
            end
            ST_LOCAL: begin
                if (convDone) begin
                    state_nxt = ST_REMOTE;
                end
            end
            ST_REMOTE: begin
                if (convDone) begin
                    state_nxt = ST_UPDATE;
                end
            end
            ST_UPDATE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer, result capture and alert drive
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r         <= ST_IDLE;
            convStart       <= 1'b0;
            convRemote      <= 1'b0;
            localWord_r     <= 16'h0000;
            remoteVal_r     <= 14'h0000;
            remoteFine_r    <= 1'b0;
            criticalAlertOe <= 1'b0;
            overtempAlertOe <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            convStart <= roundStart || localDone;
            if (roundStart) begin
                convRemote <= 1'b0;
            end else if (localDone) begin
                convRemote <= 1'b1;
            end
            // results land only at completion, so reads never see partial data
            if (localDone) begin
                localWord_r <= {localSample, 5'b00000};
            end
            // filter off keeps the coarse reading, so its low two bits never count
            if (remoteDone) begin
                remoteVal_r  <= filterOn ? remoteFiltered : {remoteSample[13:2], 2'b00};
                remoteFine_r <= filterOn;
            end
            // alerts follow one full set of results
            if (state_r == ST_UPDATE) begin
                criticalAlertOe <= critAny;
                overtempAlertOe <= otAny;
            end
        end
    end

    // register writes; one-shot request set wins over its clear
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            config1_r     <= `TLC_RST_CONFIG1;
            config2_r     <= `TLC_RST_CONFIG2;
            localLim_r    <= `TLC_RST_LOCAL_LIM;
            remCritLim_r  <= `TLC_RST_REMCRIT_LIM;
            remOtLim_r    <= `TLC_RST_REMOT_LIM;
            oneShotPend_r <= 1'b0;
        end else begin
            // configuration bytes are kept whole, reserved bits included
            if (apbWrite && paddr == `TLC_OFS_CONFIG1) begin
                config1_r <= pwdata[7:0];
            end
            if (apbWrite && paddr == `TLC_OFS_CONFIG2) begin
                config2_r <= pwdata[7:0];
            end
            // limits are unsigned whole degrees; upper data bits are dropped
            if (apbWrite && paddr == `TLC_OFS_LOCAL_LIM) begin
                localLim_r <= pwdata[6:0];
            end
            if (apbWrite && paddr == `TLC_OFS_REMCRIT_LIM) begin
                remCritLim_r <= pwdata[7:0];
            end
            if (apbWrite && paddr == `TLC_OFS_REMOT_LIM) begin
                remOtLim_r <= pwdata[7:0];
            end
            // written data is dropped; only the request survives
            if (apbWrite && paddr == `TLC_OFS_ONESHOT && standby) begin
                oneShotPend_r <= 1'b1;
            end else if (roundStart) begin
                oneShotPend_r <= 1'b0;
            end
        end
    end

    // read data captured in the setup cycle, valid across the access cycle
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apbSetup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            case (paddr)
                `TLC_OFS_LOCAL_HI:    prdata[7:0] <= localWord_r[15:8];
                `TLC_OFS_LOCAL_LO:    prdata[7:0] <= localWord_r[7:0];
                `TLC_OFS_REMS_HI:     prdata[7:0] <= remSigned[15:8];
                `TLC_OFS_REMS_LO:     prdata[7:0] <= remSigned[7:0];
                `TLC_OFS_REMU_HI:     prdata[7:0] <= remUnsign[15:8];
                `TLC_OFS_REMU_LO:     prdata[7:0] <= remUnsign[7:0];
                `TLC_OFS_CONFIG1:     prdata[7:0] <= config1_r;
                `TLC_OFS_CONFIG2:     prdata[7:0] <= config2_r;
                `TLC_OFS_ONESHOT:     prdata[7:0] <= 8'h00;
                `TLC_OFS_LOCAL_LIM:   prdata[6:0] <= localLim_r;
                `TLC_OFS_REMCRIT_LIM: prdata[7:0] <= remCritLim_r;
                `TLC_OFS_REMOT_LIM:   prdata[7:0] <= remOtLim_r;
                `TLC_OFS_PINS:        prdata[1:0] <= {otPinSync_r[1], critPinSync_r[1]};
                // status bits are live, so a limit write shows at once
                `TLC_OFS_STATUS1: begin
                    prdata[`TLC_S1_BUSY]     <= busy;
                    prdata[`TLC_S1_LOC_HIGH] <= localHigh;
                    prdata[`TLC_S1_REM_CRIT] <= remCrit;
                    prdata[`TLC_S1_REM_OT]   <= remOt;
                end
                // unmapped offsets flag an error and read as zero
                default:              pslverr <= 1'b1;
            endcase
        end
    end

    // pin synchronisers; first stage feeds only the second
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            smbClkSync_r  <= 2'b11;
            smbDatSync_r  <= 2'b11;
            critPinSync_r <= 2'b11;
            otPinSync_r   <= 2'b11;
        end else begin
            smbClkSync_r  <= {smbClkSync_r[0], smbClkIn};
            smbDatSync_r  <= {smbDatSync_r[0], smbDatIn};
            critPinSync_r <= {critPinSync_r[0], criticalAlertIn};
            otPinSync_r   <= {otPinSync_r[0], overtempAlertIn};
        end
    end

    // bus low-time watchdog; holds the engine in reset until both lines are high
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lowCount_r     <= 21'd0;
            smbEngineReset <= 1'b0;
        end else begin
            // either line low counts; both high again clears count and reset
            if (smbClkSync_r[1] && smbDatSync_r[1]) begin
                lowCount_r     <= 21'd0;
                smbEngineReset <= 1'b0;
            end else if (!timedOut) begin
                lowCount_r <= lowCount_r + 21'd1;
            end else begin
                smbEngineReset <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ---- tb/tlc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlc_chk #(
    parameter int TIMEOUT_CYCLES = 50
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic convStart,
    input wire logic convRemote,
    input wire logic convDone,
    input wire logic smbClkIn,
    input wire logic smbDatIn,
    input wire logic smbDatDriveReq,
    input wire logic smbDatOe,
    input wire logic smbClkOe,
    input wire logic smbEngineReset,
    input wire logic criticalAlertOut,
    input wire logic criticalAlertOe,
    input wire logic overtempAlertOut,
    input wire logic overtempAlertOe
);
    int         lowCnt;
    logic [3:0] doneHist;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // low run length saturates so the late bound is met only once
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lowCnt   <= 0;
            doneHist <= 4'h0;
        end else begin
            lowCnt   <= (smbClkIn && smbDatIn) ? 0 : lowCnt + (lowCnt < TIMEOUT_CYCLES + 9);
            doneHist <= {doneHist[2:0], convDone && convRemote};
        end
    end
    property p_start_pulse; convStart |=> !convStart; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too wide");
    property p_remote_follows; $rose(convRemote) |-> convStart; endproperty
    a_remote_follows: assert property (p_remote_follows) else $error("remote pass without start");
    // alerts move only just after a finished remote conversion
    property p_alert_update; !$stable({criticalAlertOe, overtempAlertOe}) |-> |doneHist; endproperty
    a_alert_update: assert property (p_alert_update) else $error("alert moved outside update");
    property p_alert_od; !criticalAlertOut && !overtempAlertOut; endproperty
    a_alert_od: assert property (p_alert_od) else $error("alert pin driven high");
    property p_bus_release; smbDatOe == (smbDatDriveReq && !smbEngineReset) && !smbClkOe; endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus pin not released");
    property p_tmo_early; $rose(smbEngineReset) |-> lowCnt >= TIMEOUT_CYCLES; endproperty
    a_tmo_early: assert property (p_tmo_early) else $error("bus timeout too early");
    property p_tmo_late; lowCnt == TIMEOUT_CYCLES + 8 |-> smbEngineReset; endproperty
    a_tmo_late: assert property (p_tmo_late) else $error("bus timeout too late");
    property p_tmo_clear; (smbClkIn && smbDatIn) [*6] |-> !smbEngineReset; endproperty
    a_tmo_clear: assert property (p_tmo_clear) else $error("bus reset stuck");
    c_remote: cover property (convStart && convRemote);
    c_timeout: cover property ($rose(smbEngineReset));
    c_alert: cover property ($rose(criticalAlertOe));
endmodule
bind tlc_sensor tlc_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_tlc_chk (.clock(clock), .nrst(nrst),
    .convStart(convStart), .convRemote(convRemote), .convDone(convDone), .smbClkIn(smbClkIn),
    .smbDatIn(smbDatIn), .smbDatDriveReq(smbDatDriveReq), .smbDatOe(smbDatOe), .smbClkOe(smbClkOe),
    .smbEngineReset(smbEngineReset), .criticalAlertOut(criticalAlertOut), .criticalAlertOe(criticalAlertOe),
    .overtempAlertOut(overtempAlertOut), .overtempAlertOe(overtempAlertOe));
`default_nettype wire

// ---- tb/tlc_front_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlc_front_model (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        convStart,
    input  wire logic [10:0] locVal,
    input  wire logic [13:0] remVal,
    input  wire logic [13:0] filtVal,
    output var  logic        convDone,
    output wire logic [10:0] localSample,
    output wire logic [13:0] remoteSample,
    output wire logic [13:0] remoteFiltered
);
    int waitCnt;
    // random 2..9 cycle conversions give both prompt and slow answers
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            convDone <= 1'b0;
            waitCnt  <= 0;
        end else begin
            convDone <= (waitCnt == 1);
            if (convStart)
                waitCnt <= 2 + $urandom % 8;
            else if (waitCnt > 0)
                waitCnt <= waitCnt - 1;
        end
    end
    // data is valid only in the done cycle, so a late latch reads garbage
    assign localSample    = convDone ? locVal : ~locVal;
    assign remoteSample   = convDone ? remVal : ~remVal;
    assign remoteFiltered = convDone ? filtVal : ~filtVal;
endmodule
`default_nettype wire

// ---- tb/tlc_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tlc_regs.vh"
module testbench;
    localparam int TMO = 50;
    logic        clock, nrst, psel, penable, pwrite, pready, pslverr, rde, convStart, convRemote, convDone;
    logic        smbClkIn, smbDatIn, smbDatOut, smbDatOe, smbClkOut, smbClkOe, smbEngineReset;
    logic        driveReq, clkLow, critIn, critOut, critOe, otIn, otOut, otOe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic [10:0] localSample, locVal;
    logic [13:0] remoteSample, remoteFiltered, remVal, filtVal;
    int          num_errors, check_count, cycles, starts, ll, rc, ro, m, code, rem, loc, s;
    // open-drain lines with pull-ups
    assign smbClkIn = !(smbClkOe && !smbClkOut) && !clkLow;
    assign smbDatIn = !(smbDatOe && !smbDatOut);
    assign critIn   = !(critOe && !critOut);
    assign otIn     = !(otOe && !otOut);
    tlc_sensor #(.TIMEOUT_CYCLES(TMO)) u_tlc_sensor (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convStart(convStart), .convRemote(convRemote), .convDone(convDone), .localSample(localSample),
        .remoteSample(remoteSample), .remoteFiltered(remoteFiltered), .smbClkIn(smbClkIn), .smbDatIn(smbDatIn),
        .smbDatDriveReq(driveReq), .smbDatOut(smbDatOut), .smbDatOe(smbDatOe), .smbClkOut(smbClkOut),
        .smbClkOe(smbClkOe), .smbEngineReset(smbEngineReset), .criticalAlertIn(critIn),
        .criticalAlertOut(critOut), .criticalAlertOe(critOe), .overtempAlertIn(otIn),
        .overtempAlertOut(otOut), .overtempAlertOe(otOe));
    tlc_front_model u_tlc_front_model (.clock(clock), .nrst(nrst), .convStart(convStart), .locVal(locVal),
        .remVal(remVal), .filtVal(filtVal), .convDone(convDone), .localSample(localSample),
        .remoteSample(remoteSample), .remoteFiltered(remoteFiltered));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // watchdog and conversion start counter
    always @(posedge clock) begin
        cycles <= cycles + 1;
        starts <= starts + convStart;
        if (cycles == 60000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; held until pready is seen high, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) num_errors++;
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdq, {24'h0, exp});
    endtask
    // waits for a finished remote conversion plus the alert update behind it
    task automatic round();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!(convDone === 1'b1 && convRemote === 1'b1) && n < 300);
        if (n >= 300) num_errors++;
        repeat (4) @(posedge clock);
    endtask
    // clamps to the signed or unsigned range; low bits stay zero with the filter off
    function automatic logic [15:0] remWord(input int v, input logic uns, input logic filt);
        int t;
        t = uns ? (v < 0 ? 0 : v) : (v > 4095 ? 4095 : (v < -4096 ? -4096 : v));
        remWord = {t[12:0], 3'h0};
        if (!filt) remWord[4:3] = 2'h0;
    endfunction
    task automatic check_all(input logic filt);
        int          v;
        logic        lh, rh, oh;
        logic [15:0] lw, sw, uw;
        v = filt ? rem : rem & ~3;
        lh = loc > ll * 8;
        rh = v > rc * 32;
        oh = v > ro * 32;
        lw = {locVal, 5'h00};
        sw = remWord(v, 1'b0, filt);
        uw = remWord(v, 1'b1, filt);
        rchk(`TLC_OFS_LOCAL_HI, lw[15:8]);
        rchk(`TLC_OFS_LOCAL_LO, lw[7:0]);
        rchk(`TLC_OFS_REMS_HI, sw[15:8]);
        rchk(`TLC_OFS_REMS_LO, sw[7:0]);
        rchk(`TLC_OFS_REMU_HI, uw[15:8]);
        rchk(`TLC_OFS_REMU_LO, uw[7:0]);
        apb(1'b0, `TLC_OFS_STATUS1, 32'h0);
        chk({29'h0, rdq[4], rdq[3], rdq[1]}, {29'h0, lh, rh, oh});
        chk({30'h0, critOe, otOe}, {30'h0, (lh && !m[0]) || (rh && !m[2]), (lh && !m[1]) || (oh && !m[3])});
        apb(1'b0, `TLC_OFS_PINS, 32'h0);
        chk({30'h0, rdq[1:0]}, {30'h0, !otOe, !critOe});
    endtask
    initial begin
        {nrst, psel, penable, pwrite, driveReq, clkLow, paddr, pwdata} = '0;
        {locVal, remVal, filtVal, num_errors, check_count, cycles, starts} = '0;
        s = $urandom(51727);
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rchk(`TLC_OFS_LOCAL_LIM, 8'h55);
        rchk(`TLC_OFS_REMCRIT_LIM, 8'h6E);
        rchk(`TLC_OFS_REMOT_LIM, 8'h55);
        rchk(`TLC_OFS_CONFIG2, 8'h1F);
        rchk(8'h38, 8'h00);
        chk({31'h0, rde}, 32'h1);
        apb(1'b1, `TLC_OFS_LOCAL_LIM, 32'hFF);
        rchk(`TLC_OFS_LOCAL_LIM, 8'h7F);
        $display("test reset and limits done");
        // code 0 filter on, 1 off, 2 and 3 reserved; first two passes sit on the local and remote critical limits
        for (int k = 0; k < 12; k++) begin
            ll = $urandom % 120;
            rc = $urandom % 250;
            ro = $urandom % 250;
            m = $urandom % 16;
            code = k % 4;
            loc = ll * 8 - 16 + $urandom % 33;
            rem = (k % 2 ? rc : ro) * 32 - 64 + $urandom % 129;
            if (k < 2) loc = ll * 8;
            if (k < 2) rem = rc * 32 + k;
            locVal <= loc[10:0];
            filtVal <= code == 0 ? rem[13:0] : ~rem[13:0];
            remVal <= code == 0 ? ~rem[13:0] : rem[13:0];
            apb(1'b1, `TLC_OFS_LOCAL_LIM, ll);
            apb(1'b1, `TLC_OFS_REMCRIT_LIM, rc);
            apb(1'b1, `TLC_OFS_REMOT_LIM, ro);
            apb(1'b1, `TLC_OFS_CONFIG1, m);
            apb(1'b1, `TLC_OFS_CONFIG2, 32'h19 | ((code + 3) % 4) * 2);
            round();
            round();
            check_all(code == 0);
        end
        $display("test compare and format done");
        m = 0;
        apb(1'b1, `TLC_OFS_CONFIG1, 32'h40);
        repeat (40) @(posedge clock);
        s = starts;
        ll = 10;
        loc = 400;
        locVal <= 11'h190;
        apb(1'b1, `TLC_OFS_LOCAL_LIM, ll);
        repeat (100) @(posedge clock);
        chk(starts - s, 0);
        apb(1'b0, `TLC_OFS_STATUS1, 32'h0);
        chk({31'h0, rdq[7]}, 32'h0);
        apb(1'b1, `TLC_OFS_ONESHOT, 32'hA5);
        apb(1'b0, `TLC_OFS_STATUS1, 32'h0);
        chk({31'h0, rdq[7]}, 32'h1);
        repeat (100) @(posedge clock);
        chk(starts - s, 2);
        check_all(1'b0);
        rchk(`TLC_OFS_ONESHOT, 8'h00);
        $display("test standby done");
        driveReq <= 1'b1;
        clkLow <= 1'b1;
        repeat (TMO - 5) @(posedge clock);
        chk({31'h0, smbDatOe}, 32'h1);
        repeat (20) @(posedge clock);
        chk({31'h0, smbDatOe}, 32'h0);
        driveReq <= 1'b0;
        clkLow <= 1'b0;
        repeat (10) @(posedge clock);
        chk({31'h0, smbEngineReset}, 32'h0);
        $display("test bus timeout done");
        end_sim();
    end
endmodule
`default_nettype wire
